// >>> inc/console_consts.svh
// constants for the operator console keypad and bus takeover block
`ifndef CONSOLE_CONSTS_SVH
`define CONSOLE_CONSTS_SVH

// ----------------------------------------
// bus addresses and widths
// ----------------------------------------
`define ADDR_W 18
`define SWITCH_REG_ADDR 18'o777570
`define PC_REG_ADDR 18'o777707
`define POINTER_STEP 18'h00002

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ 125000
`define INIT_TIME_MS 150
`define INIT_CYCLES (`INIT_TIME_MS * `CLK_KHZ)

// ----------------------------------------
// firmware port offsets
// ----------------------------------------
`define PORT_BUS_DATA 4'h0
`define PORT_BUS_ADDR 4'h1
`define PORT_KEYPAD 4'h2
`define PORT_MICROSEQ 4'h3
`define PORT_STATUS 4'h4
`define PORT_LAMPS 4'h8
`define PORT_RELEASE 4'h9
`define PORT_FORCE 4'hA

// ----------------------------------------
// lamp field positions (firmware write data bits 4..7)
// ----------------------------------------
`define LAMP_LSB 4
`define LAMP_BUS_FAULT 0
`define LAMP_SR_SHOWN 1
`define LAMP_SERVICE 2
`define LAMP_BOOT 3

`endif

// >>> inc/console_pkg.sv
// types shared by the console keypad and bus takeover block
package console_pkg;
    // key codes from the keypad encoder
    typedef enum logic [4:0] {
        KEY_CLEAR = 5'h08, KEY_LOAD_SW = 5'h09, KEY_LOAD_PTR = 5'h0A,
        KEY_SHOW_PTR = 5'h0B, KEY_WRITE = 5'h0C, KEY_READ = 5'h0D,
        KEY_STOP_STEP = 5'h0E, KEY_CONT = 5'h0F, KEY_BOOT = 5'h10,
        KEY_START = 5'h11, KEY_INIT = 5'h12
    } key_t;
    // command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_TAKE = 3'b001, ST_XFER = 3'b010,
        ST_WAIT = 3'b011, ST_INIT = 3'b100
    } state_t;
    // bus operation held while the bus is being taken
    typedef enum logic [1:0] {
        OP_READ = 2'b00, OP_WRITE = 2'b01, OP_PC = 2'b10, OP_START = 2'b11
    } op_t;
endpackage

// >>> logic/console_keypad_bus_takeover.sv
// keypad command interpreter with six-digit display and bus takeover latches
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "console_consts.svh"

module console_keypad_bus_takeover
#(
    parameter int unsigned INIT_CYCLES = `INIT_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // keypad pins
    input wire logic keyDown,
    input wire logic [4:0] keyCode,
    input wire logic modifierHeld,
    // processor arbitration pins
    input wire logic grantIn,
    input wire logic busBusyIn,
    input wire logic slaveSyncIn,
    input wire logic busInitIn,
    output logic takeoverReq,
    output logic selectionAcknowledge,
    output logic busBusyOut,
    output logic busInitOut,
    output logic runLamp,
    // processor control pulses
    output logic stepPulse,
    output logic contPulse,
    output logic startPulse,
    output logic bootPulse,
    input wire logic [15:0] microsequenceCounter,
    // bus master engine, same clock
    output console_pkg::op_t mOp,
    output logic mReq,
    output logic mWrite,
    output logic [`ADDR_W-1:0] mAddr,
    output logic [`ADDR_W-1:0] mWdata,
    input wire logic mDone,
    input wire logic mErr,
    input wire logic [`ADDR_W-1:0] mRdata,
    // bus slave view of the switch register
    input wire logic [`ADDR_W-1:0] slvAddr,
    input wire logic slvRead,
    output logic [15:0] slvRdata,
    output logic slvHit,
    // bus data and address as seen on the bus
    input wire logic [7:0] busDataIn,
    input wire logic [7:0] busAddrIn,
    // firmware port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [7:0] memRdata,
    // display and lamps
    output logic [`ADDR_W-1:0] display,
    output logic [3:0] lamps
);
    import console_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // 18-bit wrap-around add, used by the arithmetic keys
    function automatic logic [`ADDR_W-1:0] add18(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] b);
        add18 = a + b;
    endfunction

    localparam int unsigned CNT_W = $clog2(INIT_CYCLES + 1);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] keyMeta; // first stages, read only by second stages
    logic [1:0] keySync; // keyDown, modifier after two flops
    logic [4:0] codeMeta;
    logic [4:0] codeSync;
    logic [3:0] arbMeta; // grant, busy, slave sync, init
    logic [3:0] arbSync;
    logic keyPrev; // last synchronised key level for edge detect

    // two flops on every keypad and arbitration pin
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            keyMeta <= 2'h0;
            keySync <= 2'h0;
            codeMeta <= 5'h00;
            codeSync <= 5'h00;
            arbMeta <= 4'h0;
            arbSync <= 4'h0;
            keyPrev <= 1'b0;
        end
        else
        begin
            keyMeta <= {modifierHeld, keyDown};
            keySync <= keyMeta;
            codeMeta <= keyCode;
            codeSync <= codeMeta;
            arbMeta <= {busInitIn, slaveSyncIn, busBusyIn, grantIn};
            arbSync <= arbMeta;
            keyPrev <= keySync[0];
        end
    end

    wire grantS = arbSync[0];
    wire busyS = arbSync[1];
    wire syncS = arbSync[2];
    wire initS = arbSync[3];
    wire modS = keySync[1];
    // one press event per press-and-release; held keys never repeat
    wire keyEvent = keySync[0] & ~keyPrev;
    // the code lines are stable once the key level has settled
    wire [4:0] code = codeSync;
    wire isDigit = (code[4:3] == 2'b00);

    // ----------------------------------------
    // takeover latches
    // ----------------------------------------
    logic ackLatch; // grant_ack_latch
    logic ownerLatch; // bus owner
    logic seqRelease; // sequencer gives the bus back
    logic fwWr; // firmware write decode
    wire fwReleaseStrobe = regWr & (regAddr == `PORT_RELEASE);
    wire fwForceOwnership = regWr & (regAddr == `PORT_FORCE);
    // bus initialize from either side also clears the latches
    wire clearLatches = initS | busInitOut | fwReleaseStrobe | seqRelease;
    wire busFree = ~busyS & ~syncS;

    // clear beats set: a release hands the bus back
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ackLatch <= 1'b0;
            ownerLatch <= 1'b0;
        end
        else if (clearLatches)
        begin
            ackLatch <= 1'b0;
            ownerLatch <= 1'b0;
        end
        else
        begin
            // grant, ours or from a halt instruction, sets acknowledge
            if (grantS)
                ackLatch <= 1'b1;
            // own the bus once busy and slave sync are both released
            if (fwForceOwnership)
                ownerLatch <= 1'b1;
            else if (ackLatch & busFree)
                ownerLatch <= 1'b1;
        end
    end

    // arbitration outputs straight from flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            selectionAcknowledge <= 1'b0;
            busBusyOut <= 1'b0;
            runLamp <= 1'b0;
        end
        else
        begin
            selectionAcknowledge <= ackLatch;
            busBusyOut <= ownerLatch;
            runLamp <= ~ownerLatch;
        end
    end

    // processor is halted while the console owns the bus
    wire halted = ownerLatch;
    logic ownerPrev; // for spotting a halt-instruction grant
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ownerPrev <= 1'b0;
        else
            ownerPrev <= ownerLatch;
    end
    wire ownerRise = ownerLatch & ~ownerPrev;

    // ----------------------------------------
    // firmware port
    // ----------------------------------------
    // each port source gated by its own strobe, then ORed with the memory data
    wire [7:0] gData = (regRd && regAddr == `PORT_BUS_DATA) ? busDataIn : 8'h00;
    wire [7:0] gAddr = (regRd && regAddr == `PORT_BUS_ADDR) ? busAddrIn : 8'h00;
    wire [7:0] gKey = (regRd && regAddr == `PORT_KEYPAD) ? {modS, 2'h0, code} : 8'h00;
    wire [7:0] gSeq = (regRd && regAddr == `PORT_MICROSEQ) ? microsequenceCounter[7:0] : 8'h00;
    wire [7:0] gStat = (regRd && regAddr == `PORT_STATUS) ? {6'h00, ackLatch, ownerLatch} : 8'h00;
    // memory data joins the or ungated; unmapped addresses read the memory data
    wire [7:0] internalInputBus = gData | gAddr | gKey | gSeq | gStat | memRdata;
    assign fwWr = regWr & (regAddr == `PORT_LAMPS);

    // read data stands the cycle after the read strobe only
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            regRdata <= 8'h00;
        else if (regRd)
            regRdata <= internalInputBus;
        else
            regRdata <= 8'h00;
    end

    // ----------------------------------------
    // keypad registers
    // ----------------------------------------
    logic [`ADDR_W-1:0] switchReg;
    logic [`ADDR_W-1:0] pointer;
    logic [`ADDR_W-1:0] tempReg;
    state_t state;
    op_t op;
    logic [CNT_W-1:0] initCount;
    wire idle = (state == ST_IDLE);
    // a key taken only when no bus command is in flight
    wire press = keyEvent & idle;
    wire mPress = press & modS;
    wire pPress = press & ~modS;

    // switch register visible to the bus at its fixed address
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            slvRdata <= 16'h0000;
            slvHit <= 1'b0;
        end
        else
        begin
            slvHit <= slvRead & (slvAddr == `SWITCH_REG_ADDR);
            slvRdata <= (slvRead && slvAddr == `SWITCH_REG_ADDR) ? switchReg[15:0] : 16'h0000;
        end
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    // continue resumes only while the console owns the bus
    wire doCont = mPress & (code == KEY_CONT);
    wire doStep = pPress & (code == KEY_STOP_STEP) & halted;
    wire doHalt = mPress & (code == KEY_STOP_STEP) & ~halted;
    wire doStart = mPress & (code == KEY_START) & halted;
    wire doBoot = mPress & (code == KEY_BOOT) & halted;
    wire doInit = mPress & (code == KEY_INIT) & halted;
    wire doRead = pPress & (code == KEY_READ) & halted;
    wire doWrite = pPress & (code == KEY_WRITE) & halted;
    logic ackPending; // our own request is outstanding
    wire halInstr = idle & ownerRise & ~ackPending;

    // bus command sequencing and processor pulses
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            op <= OP_READ;
            takeoverReq <= 1'b0;
            ackPending <= 1'b0;
            seqRelease <= 1'b0;
            stepPulse <= 1'b0;
            contPulse <= 1'b0;
            startPulse <= 1'b0;
            bootPulse <= 1'b0;
            busInitOut <= 1'b0;
            initCount <= '0;
            mReq <= 1'b0;
            mWrite <= 1'b0;
            mOp <= OP_READ;
            mAddr <= '0;
            mWdata <= '0;
        end
        else
        begin
            // pulses last one cycle by default
            seqRelease <= 1'b0;
            stepPulse <= 1'b0;
            contPulse <= 1'b0;
            startPulse <= 1'b0;
            bootPulse <= 1'b0;
            mReq <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (doHalt)
                    begin
                        takeoverReq <= 1'b1;
                        ackPending <= 1'b1;
                        op <= OP_PC;
                        state <= ST_TAKE;
                    end
                    else if (doStep)
                    begin
                        // let go, step once, then ask for the bus again
                        seqRelease <= 1'b1;
                        stepPulse <= 1'b1;
                        takeoverReq <= 1'b1;
                        ackPending <= 1'b1;
                        op <= OP_PC;
                        state <= ST_TAKE;
                    end
                    else if (doRead | doWrite | doStart)
                    begin
                        op <= doRead ? OP_READ : (doWrite ? OP_WRITE : OP_START);
                        state <= ST_XFER;
                    end
                    else if (doCont & halted)
                    begin
                        seqRelease <= 1'b1;
                        contPulse <= 1'b1;
                    end
                    else if (doBoot)
                    begin
                        seqRelease <= 1'b1;
                        bootPulse <= 1'b1;
                    end
                    else if (doInit)
                    begin
                        busInitOut <= 1'b1;
                        initCount <= CNT_W'(INIT_CYCLES - 1);
                        state <= ST_INIT;
                    end
                    else if (halInstr)
                    begin
                        // self-halt: show where it stopped
                        op <= OP_PC;
                        state <= ST_XFER;
                    end
                end
                ST_TAKE:
                begin
                    // wait until the bus is ours
                    if (ownerLatch & ~seqRelease)
                    begin
                        takeoverReq <= 1'b0;
                        ackPending <= 1'b0;
                        state <= ST_XFER;
                    end
                    else if (ackLatch & ~seqRelease)
                        takeoverReq <= 1'b0;
                end
                ST_XFER:
                begin
                    // no transaction unless ownership is confirmed
                    if (ownerLatch)
                    begin
                        mReq <= 1'b1;
                        mOp <= op;
                        mWrite <= (op == OP_WRITE) | (op == OP_START);
                        mAddr <= (op == OP_READ || op == OP_WRITE) ? pointer : `PC_REG_ADDR;
                        mWdata <= (op == OP_START) ? pointer : display;
                        state <= ST_WAIT;
                    end
                    else
                        state <= ST_IDLE;
                end
                ST_WAIT:
                begin
                    if (mDone)
                    begin
                        state <= ST_IDLE;
                        if (op == OP_START && !mErr)
                        begin
                            seqRelease <= 1'b1;
                            startPulse <= 1'b1;
                        end
                    end
                end
                ST_INIT:
                begin
                    // bus initialize held for the full interval
                    if (initCount == '0)
                    begin
                        busInitOut <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else
                        initCount <= initCount - CNT_W'(1);
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // display, switch register, pointer, lamps
    // ----------------------------------------
    wire rdDone = (state == ST_WAIT) & mDone;
    // key decode for the display keys, plain and with modifier
    wire kClear = pPress & (code == KEY_CLEAR);
    wire kDigit = pPress & isDigit;
    wire kLoadSw = pPress & (code == KEY_LOAD_SW);
    wire kLoadPtr = pPress & (code == KEY_LOAD_PTR);
    wire kShowPtr = pPress & (code == KEY_SHOW_PTR);
    wire kAdd7 = mPress & (code == 5'h07);
    wire kAdd6 = mPress & (code == 5'h06);
    wire kService = mPress & (code == 5'h01);
    wire [`ADDR_W-1:0] sum7 = add18(tempReg, add18(pointer, `POINTER_STEP));
    wire [`ADDR_W-1:0] sum6 = add18(tempReg, switchReg);

    // display and data registers; earlier branches win on a tie
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            display <= '0;
            switchReg <= '0;
            pointer <= '0;
            tempReg <= '0;
        end
        else if (kClear)
            display <= '0;
        else if (kDigit)
            display <= {display[`ADDR_W-4:0], code[2:0]};
        else if (kLoadSw)
            switchReg <= display;
        else if (kLoadPtr)
        begin
            pointer <= display;
            display <= '0;
        end
        else if (kShowPtr)
            display <= pointer;
        else if (kAdd7)
        begin
            tempReg <= sum7;
            display <= sum7;
        end
        else if (kAdd6)
        begin
            tempReg <= sum6;
            display <= sum6;
        end
        else if (kService)
            display <= {2'b00, microsequenceCounter};
        else if (doCont)
            display <= switchReg;
        else if (startPulse)
            display <= switchReg;
        else if (rdDone && !mErr && op != OP_WRITE && op != OP_START)
        begin
            display <= mRdata;
            tempReg <= mRdata;
        end
    end

    // lamps: firmware latch first, keypad effects on top
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            lamps <= 4'h0;
        else if (fwWr)
            lamps <= regWdata[`LAMP_LSB+3:`LAMP_LSB];
        else if (kClear)
        begin
            lamps[`LAMP_BUS_FAULT] <= 1'b0;
            lamps[`LAMP_SR_SHOWN] <= 1'b0;
            lamps[`LAMP_SERVICE] <= 1'b0;
        end
        else if (kLoadSw | doCont | startPulse)
            lamps[`LAMP_SR_SHOWN] <= 1'b1;
        else if (halInstr)
            lamps[`LAMP_SR_SHOWN] <= 1'b0;
        else if (kService)
            lamps[`LAMP_SERVICE] <= 1'b1;
        else if (rdDone & mErr)
            lamps[`LAMP_BUS_FAULT] <= 1'b1;
    end
endmodule

// >>> bench/console_keypad_bus_takeover_monitor.sv
// assertion checker for the console block
`timescale 1ns/10ps
`include "console_consts.svh"
module console_keypad_bus_takeover_monitor
#(
    parameter int unsigned INIT_CYCLES = 20
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // takeover pins
    input wire logic grantIn,
    input wire logic busInitIn,
    input wire logic selectionAcknowledge,
    input wire logic busBusyOut,
    input wire logic busInitOut,
    input wire logic runLamp,
    // probe and port
    input wire logic [`ADDR_W-1:0] slvAddr,
    input wire logic slvRead,
    input wire logic slvHit,
    input wire logic [3:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] memRdata
);
    // ----------------------------------------
    // init pulse length
    // ----------------------------------------
    int unsigned initLen;
    always_ff @(posedge ref_clk)
    begin
        initLen <= (rst || !busInitOut) ? 0 : initLen + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_ack; (grantIn && !busInitOut) [*4] |=> selectionAcknowledge; endproperty
    a_ack: assert property (p_ack) else $error("acknowledge late");
    property p_run; !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> runLamp == !busBusyOut; endproperty
    a_run: assert property (p_run) else $error("run lamp wrong");
    property p_stat; regRd && regAddr == `PORT_STATUS |=>
        regRdata == ({6'h00, selectionAcknowledge, busBusyOut} | $past(memRdata)); endproperty
    a_stat: assert property (p_stat) else $error("status wrong");
    property p_rel; regWr && regAddr == `PORT_RELEASE |-> ##2 !busBusyOut; endproperty
    a_rel: assert property (p_rel) else $error("release ignored");
    property p_force; regWr && regAddr == `PORT_FORCE && !busInitOut && !busInitIn |-> ##2 busBusyOut; endproperty
    a_force: assert property (p_force) else $error("force ignored");
    property p_idle; !$past(regRd) |-> regRdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_slv; slvRead && slvAddr == `SWITCH_REG_ADDR |=> slvHit; endproperty
    a_slv: assert property (p_slv) else $error("switch reg miss");
    property p_init; $fell(busInitOut) |-> initLen == INIT_CYCLES; endproperty
    a_init: assert property (p_init) else $error("init length wrong");
    c_own: cover property ($rose(busBusyOut));
    c_init: cover property ($fell(busInitOut));
    c_slv: cover property (slvHit);
endmodule
bind console_keypad_bus_takeover console_keypad_bus_takeover_monitor #(.INIT_CYCLES(INIT_CYCLES))
    console_keypad_bus_takeover_monitor_inst (.*);

// >>> bench/host_cpu_model.sv
// host processor model: grants the bus, serves bus cycles
`timescale 1ns/10ps
module host_cpu_model
#(
    parameter int GRANT_DLY = 3,
    parameter int XFER_DLY = 4,
    parameter logic [17:0] PC_INIT = 18'h00000
)
(
    // arbitration
    input wire logic ref_clk,
    input wire logic takeoverReq,
    input wire logic selectionAcknowledge,
    output logic grantIn = 1'b0,
    output logic busBusyIn = 1'b1,
    output logic slaveSyncIn = 1'b1,
    // console bus cycles
    input wire logic mReq,
    input wire logic mWrite,
    input wire logic [17:0] mAddr,
    input wire logic [17:0] mWdata,
    output logic mDone = 1'b0,
    output logic mErr = 1'b0,
    output logic [17:0] mRdata = 18'h00000
);
    logic [17:0] mem [logic [17:0]];
    int cnt = 0, xc = 0;
    initial mem[18'o777707] = PC_INIT;
    // grant after arbitration; busy, sync trail acknowledge
    always @(posedge ref_clk)
    begin
        cnt <= (takeoverReq && !grantIn) ? cnt + 1 : 0;
        if (selectionAcknowledge)
            grantIn <= 1'b0;
        else if (cnt == GRANT_DLY)
            grantIn <= 1'b1;
        busBusyIn <= !selectionAcknowledge;
        slaveSyncIn <= busBusyIn;
    end
    // data lines toggle unless answering
    always @(posedge ref_clk)
    begin
        mDone <= 1'b0;
        mRdata <= ~mRdata;
        if (mReq)
            xc <= XFER_DLY;
        else if (xc == 1)
        begin
            if (mWrite)
                mem[mAddr] = mWdata;
            mRdata <= mem.exists(mAddr) ? mem[mAddr] : 18'h00000;
            mDone <= 1'b1;
            xc <= 0;
        end
        else if (xc > 1)
            xc <= xc - 1;
    end
endmodule

// >>> bench/console_keypad_bus_takeover_tb.sv
// self-checking testbench for the console block
`timescale 1ns/10ps
`include "console_consts.svh"
module console_keypad_bus_takeover_tb;
    import console_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, keyDown = 1'b0, modifierHeld = 1'b0, busInitIn = 1'b0;
    logic slvRead = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [4:0] keyCode = 5'h00;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, busDataIn = 8'h30, busAddrIn = 8'h41, memRdata = 8'h05;
    logic [15:0] microsequenceCounter = 16'h127C;
    logic [17:0] slvAddr = 18'h00000;
    // design or host outputs
    logic grantIn, busBusyIn, slaveSyncIn, takeoverReq, selectionAcknowledge, busBusyOut;
    logic busInitOut, runLamp, mReq, mWrite, mDone, mErr, slvHit;
    logic [17:0] mAddr, mWdata, mRdata, display;
    logic [15:0] slvRdata;
    logic [7:0] regRdata, d;
    logic [3:0] lamps;
    int miscompares = 0, compares = 0, dones = 0, initLen = 0;
    localparam logic [17:0] PC0 = 18'o002004;
    console_keypad_bus_takeover #(.INIT_CYCLES(20)) console_keypad_bus_takeover_inst (.*, .mOp(),
        .stepPulse(), .contPulse(), .startPulse(), .bootPulse());
    host_cpu_model #(.PC_INIT(PC0)) host_cpu_model_inst (.*);
    always #4 ref_clk = ~ref_clk;
    // bus cycles done, init length
    always @(posedge ref_clk)
    begin
        dones <= dones + (mDone === 1'b1);
        initLen <= initLen + (busInitOut === 1'b1);
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // held key would show repeats
    task automatic key(input logic [4:0] c, input logic m);
        @(posedge ref_clk);
        keyCode <= c;
        modifierHeld <= m;
        repeat (2) @(posedge ref_clk);
        keyDown <= 1'b1;
        repeat (6) @(posedge ref_clk);
        keyDown <= 1'b0;
        repeat (6) @(posedge ref_clk);
        modifierHeld <= 1'b0;
    endtask
    task automatic op(input logic [4:0] c, input logic m);
        int d0 = dones;
        key(c, m);
        for (int i = 0; i < 400 && dones == d0; i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic enter(input logic [17:0] v);
        key(KEY_CLEAR, 1'b0);
        for (int i = 5; i >= 0; i--) key({2'b00, v[3*i +: 3]}, 1'b0);
    endtask
    task automatic regW(input logic [3:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= w;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic regR(input logic [3:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic t_entry();
        enter(18'o123456);
        chk(display, 18'o123456);
        key(KEY_LOAD_SW, 1'b0);
        chk({display[15:0], 1'b0, lamps[`LAMP_SR_SHOWN]}, {16'o123456, 2'b01});
        @(posedge ref_clk);
        slvAddr <= `SWITCH_REG_ADDR;
        slvRead <= 1'b1;
        @(posedge ref_clk);
        slvRead <= 1'b0;
        #1 chk({1'b0, slvHit, slvRdata}, {2'b01, 16'o123456});
        key(KEY_CLEAR, 1'b0);
        chk({display[13:0], lamps}, 18'h0);
        $display("entry done");
    endtask
    task automatic t_pointer();
        int d0;
        enter(18'o001000);
        key(KEY_LOAD_PTR, 1'b0);
        chk(display, 18'h0);
        key(KEY_SHOW_PTR, 1'b0);
        chk(display, 18'o001000);
        d0 = dones;
        key(KEY_WRITE, 1'b0);
        repeat (40) @(posedge ref_clk);
        chk(18'(dones - d0), 18'h0);
        $display("pointer done");
    endtask
    task automatic t_halt();
        op(KEY_STOP_STEP, 1'b1);
        chk(display, PC0);
        chk({16'h0, runLamp, busBusyOut}, 18'h1);
        regR(`PORT_STATUS);
        chk({10'h0, d}, 18'h07);
        enter(18'o005252);
        op(KEY_WRITE, 1'b0);
        chk(display, 18'o005252);
        key(KEY_CLEAR, 1'b0);
        op(KEY_READ, 1'b0);
        chk(display, 18'o005252);
        op(KEY_STOP_STEP, 1'b0);
        chk({display, busBusyOut}, {PC0, 1'b1});
        $display("halt done");
    endtask
    task automatic t_ports();
        logic [3:0] a[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
        logic [7:0] e[5] = '{8'h35, 8'h45, 8'h0F, 8'h7D, 8'h05};
        for (int i = 0; i < 5; i++)
        begin
            regR(a[i]);
            chk({10'h0, d}, {10'h0, e[i]});
        end
        regW(`PORT_LAMPS, 8'hA0);
        repeat (2) @(posedge ref_clk);
        chk({14'h0, lamps}, 18'hA);
        $display("ports done");
    endtask
    task automatic t_owner();
        regW(`PORT_RELEASE, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk({16'h0, runLamp, busBusyOut}, 18'h2);
        regW(`PORT_FORCE, 8'h00);
        repeat (20) @(posedge ref_clk);
        chk({16'h0, runLamp, busBusyOut}, 18'h1);
        busInitIn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        busInitIn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({16'h0, selectionAcknowledge, busBusyOut}, 18'h0);
        op(KEY_STOP_STEP, 1'b1);
        key(KEY_INIT, 1'b1);
        repeat (30) @(posedge ref_clk);
        chk(18'(initLen), 18'd20);
        $display("owner done");
    endtask
    task automatic end_sim();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_entry();
        t_pointer();
        t_halt();
        t_ports();
        t_owner();
        end_sim();
    end
    // watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end
endmodule
